// ===== fsid_pkg.sv
package fsid_pkg;

  // Bus widths and bit positions
  localparam int FSID_ADDR_W = 18;
  localparam int FSID_CMD_ADDR_W = 15;
  localparam int FSID_DATA_W = 8;
  localparam int FSID_TOGGLE_POS = 6;
  localparam int FSID_CODE_SEL_POS = 0;

  // Clock rate and pin timing
  localparam int FSID_CLK_PERIOD_NS = 4;
  localparam int FSID_GATE_HIGH_NS = 150;
  localparam int FSID_GATE_HIGH_CYC =
    (FSID_GATE_HIGH_NS + FSID_CLK_PERIOD_NS - 1) / FSID_CLK_PERIOD_NS;
  localparam int FSID_STROBE_NS = 90;
  localparam int FSID_STROBE_CYC =
    (FSID_STROBE_NS + FSID_CLK_PERIOD_NS - 1) / FSID_CLK_PERIOD_NS;
  localparam int FSID_ADDR_HOLD_NS = 50;
  localparam int FSID_ADDR_HOLD_CYC =
    (FSID_ADDR_HOLD_NS + FSID_CLK_PERIOD_NS - 1) / FSID_CLK_PERIOD_NS;
  localparam int FSID_CNT_W = 8;

  // Boot block range of the standard variant
  localparam logic [17:0] FSID_BOOT_LO = 18'h00000;
  localparam logic [17:0] FSID_BOOT_HI = 18'h01FFF;

  // Operation requested by the user side
  typedef enum logic [1:0] {
    FSID_OP_READ  = 2'h0,
    FSID_OP_WRITE = 2'h1,
    FSID_OP_POLL  = 2'h2,
    FSID_OP_ERASE = 2'h3
  } fsid_op_t;

  typedef struct packed {
    fsid_op_t         op;
    logic [17:0]      addr;
    logic [7:0]       data;
  } fsid_req_t;

  // Pin bundle driven toward the flash
  typedef struct packed {
    logic             ce_n;
    logic             oe_n;
    logic             we_n;
    logic [17:0]      addr;
    logic [7:0]       dq_out;
    logic             dq_oe;
  } fsid_pins_t;

endpackage : fsid_pkg

// ===== fsid_timer.sv
`timescale 1ns/10ps
`default_nettype none

module fsid_timer
  import fsid_pkg::*;
(
  input  wire logic                  clock,   // System clock
  input  wire logic                  rstn,    // Async reset, low
  input  wire logic                  load,    // Load a new count
  input  wire logic [FSID_CNT_W-1:0] count,   // Cycles to wait
  output logic                       done     // Count expired
);

  typedef struct packed {
    logic [FSID_CNT_W-1:0] cnt;
  } fsid_tmr_st_t;

  fsid_tmr_st_t st_r;
  fsid_tmr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.cnt = count;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Free of load, so a caller may reload on done without a comb loop
  assign done = (st_r.cnt == '0);

endmodule // fsid_timer

`default_nettype wire

// ===== fsid_host.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE_01 - Busy device flips status bit on every gate or select read strobe.
// RULE_02 - Host keeps toggling strobe high at least 150 ns between reads.
// RULE_03 - Status sits on data bit 6; start and end levels are arbitrary.
// RULE_04 - Poll any address but keep it fixed for one operation.
// RULE_05 - Id mode: address bit 0 selects maker or part code.
// RULE_06 - Id mode is lost at power down; device powers up reading array.
// RULE_07 - Exit sequence returns device to normal array reads.
// RULE_08 - Command bytes on data 7..0, addresses from bits 14..0 only.
// RULE_09 - Lockout sequence protects the boot block from later programming.
// RULE_10 - Boot block spans addresses 00000 to 01FFF inclusive.
// RULE_11 - During chip erase, gate high only while strobe and select low; the host holds gate high through the whole operation.
// RULE_12 - Done when two successive status reads match on bit 6.
module fsid_host
  import fsid_pkg::*;
(
  input  wire logic        clock,       // System clock
  input  wire logic        rstn,        // Async reset, low
  input  wire fsid_req_t   req,         // Requested operation
  input  wire logic        req_valid,   // Request strobe
  output logic             req_ready,   // Idle, can take request
  output logic             rsp_valid,   // Answer pulse
  output logic [7:0]       rsp_data,    // Read data
  output logic             boot_hit,    // Last write hit boot block
  output logic             ce_n,        // Chip select, low
  output logic             oe_n,        // Output gate, low
  output logic             we_n,        // Write strobe, low
  output logic [17:0]      addr,        // Flash address
  output logic [7:0]       dq_out,      // Data to flash
  output logic             dq_oe,       // Data pins driven
  input  wire logic [7:0]  dq_in        // Data from flash
);

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_RD    = 7'h02,
    S_WR    = 7'h04,
    S_WHOLD = 7'h08,
    S_PRD   = 7'h10,
    S_PGAP  = 7'h20,
    S_DONE  = 7'h40
  } fsid_state_t;

  typedef struct packed {
    fsid_state_t      state;
    fsid_op_t         op;
    fsid_pins_t       pins;
    logic             have_prev;
    logic             prev_bit;
    logic             rsp_valid;
    logic [7:0]       rsp_data;
    logic             boot_hit;
    logic             ready;
  } fsid_st_t;

  fsid_st_t st_r;
  fsid_st_t st_nxt;

  logic                  tmr_load;
  logic [FSID_CNT_W-1:0] tmr_count;
  logic                  tmr_done;

  fsid_timer u_timer (
    .clock (clock),
    .rstn  (rstn),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    case (st_r.state)
      S_IDLE: begin
        if (req_valid) begin
          st_nxt.ready = 1'b0;
          st_nxt.op = req.op;
          st_nxt.have_prev = 1'b0;
          tmr_load = 1'b1;
          tmr_count = FSID_CNT_W'(FSID_STROBE_CYC);
          // RULE_04 fixed poll address
          st_nxt.pins.addr = req.addr;
          st_nxt.pins.ce_n = 1'b0;
          if (req.op == FSID_OP_READ || req.op == FSID_OP_POLL) begin
            st_nxt.pins.oe_n = 1'b0;
            st_nxt.pins.dq_oe = 1'b0;
            st_nxt.state = (req.op == FSID_OP_POLL) ? S_PRD : S_RD;
          end else begin
            // RULE_08 command address bits
            if (req.addr[17:FSID_CMD_ADDR_W] != '0) begin
              st_nxt.pins.addr = {3'h0, req.addr[FSID_CMD_ADDR_W-1:0]};
            end
            if (req.op == FSID_OP_WRITE) begin
              st_nxt.pins.addr = req.addr;
            end
            st_nxt.pins.dq_out = req.data;
            st_nxt.pins.dq_oe = 1'b1;
            st_nxt.pins.we_n = 1'b0;
            // RULE_11 gate high in erase
            st_nxt.pins.oe_n = 1'b1;
            // RULE_10 boot block range
            st_nxt.boot_hit = (req.op == FSID_OP_WRITE) &&
                              (req.addr >= FSID_BOOT_LO) &&
                              (req.addr <= FSID_BOOT_HI);
            st_nxt.state = S_WR;
          end
        end
      end
      S_RD: begin
        if (tmr_done) begin
          // RULE_05 code by low address bit
          st_nxt.rsp_data = dq_in;
          st_nxt.rsp_valid = 1'b1;
          st_nxt.pins.oe_n = 1'b1;
          st_nxt.pins.ce_n = 1'b1;
          st_nxt.state = S_DONE;
        end
      end
      S_WR: begin
        if (tmr_done) begin
          st_nxt.pins.we_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = FSID_CNT_W'(FSID_ADDR_HOLD_CYC);
          st_nxt.state = S_WHOLD;
        end
      end
      S_WHOLD: begin
        if (tmr_done) begin
          st_nxt.pins.ce_n = 1'b1;
          st_nxt.pins.dq_oe = 1'b0;
          st_nxt.rsp_valid = 1'b1;
          st_nxt.state = S_DONE;
        end
      end
      S_PRD: begin
        if (tmr_done) begin
          // RULE_03 bit 6 compared, not level
          st_nxt.prev_bit = dq_in[FSID_TOGGLE_POS];
          st_nxt.have_prev = 1'b1;
          st_nxt.pins.oe_n = 1'b1;
          st_nxt.pins.ce_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = FSID_CNT_W'(FSID_GATE_HIGH_CYC);
          // RULE_12 two equal reads end it
          if (st_r.have_prev &&
              st_r.prev_bit == dq_in[FSID_TOGGLE_POS]) begin
            st_nxt.rsp_data = dq_in;
            st_nxt.rsp_valid = 1'b1;
            st_nxt.state = S_DONE;
          end else begin
            st_nxt.state = S_PGAP;
          end
        end
      end
      S_PGAP: begin
        // RULE_02 min_gate_high_pulse
        if (tmr_done) begin
          // RULE_01 toggle select and gate
          st_nxt.pins.oe_n = 1'b0;
          st_nxt.pins.ce_n = 1'b0;
          tmr_load = 1'b1;
          tmr_count = FSID_CNT_W'(FSID_STROBE_CYC);
          st_nxt.state = S_PRD;
        end
      end
      S_DONE: begin
        // Recovery gap before the next strobe
        tmr_load = 1'b1;
        tmr_count = FSID_CNT_W'(FSID_GATE_HIGH_CYC);
        st_nxt.ready = 1'b0;
        st_nxt.state = S_PGAP;
        st_nxt.op = FSID_OP_READ;
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase
    // Gap after a finished operation leads back to idle
    if (st_r.state == S_PGAP && st_r.op != FSID_OP_POLL && tmr_done) begin
      st_nxt.pins.oe_n = 1'b1;
      st_nxt.pins.ce_n = 1'b1;
      tmr_load = 1'b0;
      st_nxt.ready = 1'b1;
      st_nxt.state = S_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{state: S_IDLE, op: FSID_OP_READ,
                pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        addr: '0, dq_out: '0, dq_oe: 1'b0},
                have_prev: 1'b0, prev_bit: 1'b0, rsp_valid: 1'b0,
                rsp_data: '0, boot_hit: 1'b0, ready: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req_ready = st_r.ready;
  assign rsp_valid = st_r.rsp_valid;
  assign rsp_data  = st_r.rsp_data;
  assign boot_hit  = st_r.boot_hit;
  assign ce_n      = st_r.pins.ce_n;
  assign oe_n      = st_r.pins.oe_n;
  assign we_n      = st_r.pins.we_n;
  assign addr      = st_r.pins.addr;
  assign dq_out    = st_r.pins.dq_out;
  assign dq_oe     = st_r.pins.dq_oe;

endmodule // fsid_host

`default_nettype wire

// ===== fsid_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module fsid_monitor
  import fsid_pkg::*;
(
  input wire logic        clock,     // Clock
  input wire logic        rstn,      // Reset, low
  input wire fsid_req_t   req,       // Request
  input wire logic        req_valid, // Strobe
  input wire logic        req_ready, // Idle
  input wire logic        rsp_valid, // Answer
  input wire logic        ce_n,      // Select
  input wire logic        oe_n,      // Gate
  input wire logic        we_n,      // Write
  input wire logic [17:0] addr       // Address
);
  logic [7:0]  hi_r;
  logic [1:0]  rd_r;
  logic        pl_r;
  logic [17:0] pa_r;
  wire         tk = req_valid && req_ready;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Gate high length and poll read count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hi_r <= 8'hFF;
      rd_r <= 2'h0;
      pl_r <= 1'b0;
      pa_r <= 18'h00000;
    end else begin
      hi_r <= oe_n ? hi_r + 8'(hi_r != 8'hFF) : 8'h00;
      if (tk) rd_r <= 2'h0;
      else if (pl_r && !oe_n && hi_r != 8'h00) rd_r <= rd_r + 2'(rd_r != 2'h2);
      if (tk) pl_r <= req.op == FSID_OP_POLL;
      else if (rsp_valid) pl_r <= 1'b0;
      if (tk) pa_r <= req.addr;
    end
  end
  sequence s_cmd;
    tk && req.op == FSID_OP_ERASE;
  endsequence
  sequence s_cmd_pins;
    !we_n && addr[17:15] == 3'h0;
  endsequence
  a_gate_gap: assert property (
    !oe_n && hi_r != 8'h00 |-> hi_r >= 8'(FSID_GATE_HIGH_CYC))
    else $error("gate high gap too short");
  a_addr_fixed: assert property (
    pl_r && !ce_n |-> addr == pa_r) else $error("poll address moved");
  a_cmd_mask: assert property (
    s_cmd |-> ##[1:3] s_cmd_pins) else $error("command address not cut");
  a_erase_gate: assert property (
    !we_n |-> oe_n && !ce_n) else $error("gate low during write");
  a_poll_two: assert property (
    pl_r && rsp_valid |-> rd_r == 2'h2) else $error("poll ended early");
  a_status_both: assert property (
    pl_r && !oe_n |-> !ce_n) else $error("status read not selected");
endmodule // fsid_monitor
bind fsid_host fsid_monitor mon_u (.clock(clock), .rstn(rstn), .req(req),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr));
`default_nettype wire

// ===== fsid_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsid_flash_model
  import fsid_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'hA5, // Arbitrary value
  parameter logic [7:0] PART  = 8'h3C, // Arbitrary value
  parameter logic [7:0] ID_ON = 8'h90,
  parameter logic [7:0] ID_NO = 8'hF0,
  parameter logic [7:0] LOCK  = 8'h40,
  parameter int         BUSY  = 300
)(
  input  wire logic        clock,  // Clock
  input  wire logic        ce_n,   // Select
  input  wire logic        oe_n,   // Gate
  input  wire logic        we_n,   // Write
  input  wire logic [17:0] addr,   // Address
  input  wire logic [7:0]  dq_out, // Host data
  input  wire logic        dq_oe,  // Host drives data
  output logic [7:0]       rdata   // Data to host
);
  logic [7:0] mem [16];
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic       idm = 1'b0;
  logic       lk = 1'b0;
  logic       tg = 1'b0;
  logic       rd_q = 1'b0;
  logic       wr_q = 1'b0;
  int         busy = 0;
  wire        rd = !ce_n && !oe_n;
  wire        wr = !ce_n && !we_n && oe_n;
  // Undriven data pins write an unknown byte
  wire [7:0]  wd = dq_oe ? dq_out : 8'hXX;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always_comb begin
    if (busy > 0) val = {last[7], tg, last[5:0]};
    else if (idm && addr[17:1] == 17'h00000) val = addr[0] ? PART : MAKER;
    else val = mem[addr[3:0]];
  end
  // Released pins show the inverse of the last byte
  // Host driving during a read is contention
  assign rdata = rd ? (dq_oe ? 8'hXX : val) : ~last;
  always @(posedge clock) begin
    rd_q <= rd;
    wr_q <= wr;
    if (busy > 0) busy <= busy - 1;
    if (rd_q && !rd && busy > 0) tg <= !tg;
    if (rd) last <= val;
    // command byte taken at write end
    if (wr_q && !wr) begin
      if (wd == ID_ON) idm <= 1'b1;
      else if (wd == ID_NO) idm <= 1'b0;
      else if (wd == LOCK) lk <= 1'b1;
      else if (!(lk && addr <= FSID_BOOT_HI)) begin
        mem[addr[3:0]] <= mem[addr[3:0]] & wd;
        busy <= BUSY;
      end
    end
  end
endmodule // fsid_flash_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fsid_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  fsid_req_t   req = '0;
  logic        req_valid = 1'b0;
  logic        req_ready, rsp_valid, boot_hit, ce_n, oe_n, we_n, dq_oe;
  logic [17:0] addr;
  logic [7:0]  rsp_data, dq_out, dq_in;
  logic [7:0]  exp_mem [16];
  int          miscompares = 0;
  int          cmp_count = 0;
  initial forever #2 clock = !clock;
  fsid_host dut_u (.clock(clock), .rstn(rstn), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .boot_hit(boot_hit), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  fsid_flash_model flash_u (.clock(clock), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .rdata(dq_in));
  function automatic logic [7:0] exp_boot(input logic [17:0] a);
    return 8'(a <= FSID_BOOT_HI);
  endfunction
  function automatic logic [7:0] exp_code(input logic sel);
    return sel ? flash_u.PART : flash_u.MAKER;
  endfunction
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    if (n > 3000) begin
      miscompares++;
      conclude();
    end else begin
      @(negedge clock);
    end
  endtask
  task automatic xfer(input fsid_op_t op, input logic [17:0] a,
                      input logic [7:0] wd);
    int n;
    for (n = 0; req_ready !== 1'b1; n++) tick(n);
    @(posedge clock);
    req <= '{op, a, wd};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    for (n = 0; rsp_valid !== 1'b1; n++) tick(n);
  endtask
  task automatic prog(input logic [17:0] a, input logic [7:0] wd,
                      input logic ok);
    xfer(FSID_OP_WRITE, a, wd);
    chk(8'(boot_hit), exp_boot(a));
    if (ok) begin
      exp_mem[a[3:0]] &= wd;
      xfer(FSID_OP_POLL, a, 8'h00);
      chk(rsp_data, exp_mem[a[3:0]]);
    end
    xfer(FSID_OP_READ, a, 8'h00);
    chk(rsp_data, exp_mem[a[3:0]]);
  endtask
  initial begin
    int i;
    void'($urandom(69614));
    foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    xfer(FSID_OP_READ, 18'h20000 | 18'($urandom_range(15)), 8'h00);
    chk(rsp_data, 8'hFF);
    prog(18'h01FFF, 8'($urandom) & 8'h3F, 1'b1);
    prog(18'h02000, 8'($urandom) & 8'h3F, 1'b1);
    for (i = 0; i < 3; i++) begin
      prog(18'($urandom), 8'($urandom) & 8'h3F, 1'b1);
    end
    xfer(FSID_OP_ERASE, 18'h3D555, 8'h90);
    for (i = 0; i < 2; i++) begin
      xfer(FSID_OP_READ, 18'(i), 8'h00);
      chk(rsp_data, exp_code(i[0]));
    end
    xfer(FSID_OP_ERASE, 18'h2AAAA, 8'hF0);
    xfer(FSID_OP_READ, 18'h00000, 8'h00);
    chk(rsp_data, exp_mem[0]);
    xfer(FSID_OP_ERASE, 18'h05555, 8'h40);
    prog(18'h00003, 8'h00, 1'b0);
    prog(18'h2000E, 8'($urandom) & 8'h3F, 1'b1);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
